/* verilog/ubs_pkg.sv */
package ubs_pkg;

    ////////////////////////////////////////////////////////////////////////
    // data block kinds toward the controller
    localparam logic [2:0] KIND_HEAD   = 3'h0;
    localparam logic [2:0] KIND_BODY   = 3'h1;
    localparam logic [2:0] KIND_LAST   = 3'h2;
    localparam logic [2:0] KIND_REPORT = 3'h3;
    localparam logic [2:0] KIND_MISSED = 3'h4;

    // block type byte values, arbitrary encodings
    localparam logic [7:0] TYPE_HEAD   = 8'h01;
    localparam logic [7:0] TYPE_BODY   = 8'h02;
    localparam logic [7:0] TYPE_LAST   = 8'h03;
    localparam logic [7:0] TYPE_REPORT = 8'h04;
    localparam logic [7:0] TYPE_MISSED = 8'h05;
    localparam logic [7:0] TYPE_CHAN   = 8'h06;

    localparam int         NEWDESC_BIT = 4;
    localparam int         FIFO_DEPTH  = 16;
    localparam logic [2:0] CHAN_RST    = 3'h0;

    ////////////////////////////////////////////////////////////////////////
    // control message layout, msb first
    localparam int         CTL_W       = 74;
    localparam int         CTL_TYPE_HI = 73;
    localparam int         CTL_CHAN_HI = 70;
    localparam int         CTL_PAY_HI  = 67;
    localparam int         CHG_PAR_POS = 59;
    localparam logic [2:0] MSG_INTERVAL = 3'h0;
    localparam logic [2:0] MSG_DESC_CHG = 3'h1;
    localparam logic [3:0] USAGE_INIT_MAINT = 4'h3;
    localparam logic [2:0] SEL_REG_DEFINED  = 3'h0;

    ////////////////////////////////////////////////////////////////////////
    // serial register frame
    localparam logic [3:0] DIE_SELECT_OWN = 4'h0;
    localparam logic [1:0] SPI_BYTE_HDR   = 2'h0;
    localparam logic [1:0] SPI_BYTE_AHI   = 2'h1;
    localparam logic [1:0] SPI_BYTE_ALO   = 2'h2;
    localparam logic [1:0] SPI_BYTE_DATA  = 2'h3;

    typedef struct packed {
        logic [2:0] kind;
        logic [2:0] chan;
        logic [7:0] info;
    } ubs_blk_t;

    typedef struct packed {
        logic [2:0]  chan;
        logic [13:0] flow;
        logic [3:0]  usage;
        logic [13:0] len;
        logic [31:0] start;
        logic [2:0]  sel;
    } ubs_ivl_t;

    typedef enum logic [4:0] {
        ST_IDLE   = 5'b00001,
        ST_CHAN_T = 5'b00010,
        ST_CHAN_P = 5'b00100,
        ST_BLK_T  = 5'b01000,
        ST_BLK_I  = 5'b10000
    } ubs_state_t;

endpackage : ubs_pkg

/* verilog/ubs_fifo.sv */
`timescale 1ns/10ps
module ubs_fifo #(
    parameter int W     = 14,
    parameter int DEPTH = 16
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic         i_valid,
    output logic              o_ready,
    input  wire logic [W-1:0] i_data,
    output logic              o_valid,
    input  wire logic         i_ready,
    output logic [W-1:0]      o_data
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wp_reg;
    logic [AW-1:0] rp_reg;
    logic [AW:0]   cnt_reg;
    logic          ov_reg;
    logic [W-1:0]  od_reg;

    wire push = i_valid && o_ready;
    // refill the output register whenever it is empty or being drained
    wire load = (cnt_reg != '0) && (!ov_reg || i_ready);

    assign o_ready = cnt_reg != (AW+1)'(DEPTH);
    assign o_valid = ov_reg;
    assign o_data  = od_reg;

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wp_reg] <= i_data;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wp_reg  <= '0;
            rp_reg  <= '0;
            cnt_reg <= '0;
            ov_reg  <= 1'b0;
            od_reg  <= '0;
        end else begin
            wp_reg  <= push ? wp_reg + 1'b1 : wp_reg;
            rp_reg  <= load ? rp_reg + 1'b1 : rp_reg;
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(load);
            if (load) begin
                ov_reg <= 1'b1;
                od_reg <= mem[rp_reg];
            end else if (i_ready) begin
                ov_reg <= 1'b0;
            end
        end
    end

endmodule : ubs_fifo

/* verilog/ubs_sequencer.sv */
`timescale 1ns/10ps
// Functional notes
// - first head or missed block after descriptor change carries flag; a change landing in the cycle a start info byte is accepted stays pending for the next one
// - flag is clear in every other head or missed block
// - channel-select block is type byte plus one payload byte
// - payload bits 7:3 zero, bits 2:0 channel number
// - all blocks of a burst go out without other channels
// - channel-select precedes a start block on a new channel
// - channel-select only before start blocks, never mid burst
// - message is type, channel, payload, even parity; trailing for interval, at bit 59 for descriptor change
// - type 0 interval, type 1 descriptor change, rest reserved
// - interval payload: flow, usage, length, start slot, select
// - overlapping initial maintenance accepted on any channel
// - illegal overlap raises interrupt, holds description until ack
// - select value zero supported: register-defined report contents
// - serial frame: die select, reserved, direction, address, data
// - missed block usage byte bit 4 is the new-descriptor flag
module ubs_sequencer (
    input  wire logic                 i_clk,
    input  wire logic                 i_rst,
    input  wire logic                 i_blk_valid,
    output logic                      o_blk_ready,
    input  wire ubs_pkg::ubs_blk_t    i_blk,
    output logic [7:0]                o_byte,
    output logic                      o_byte_valid,
    input  wire logic                 i_byte_ready,
    input  wire logic                 i_chan_every_burst,
    input  wire logic                 i_ctl_valid,
    input  wire logic [73:0]          i_ctl_msg,
    output logic                      o_ivl_valid,
    output ubs_pkg::ubs_ivl_t         o_ivl,
    output logic                      o_ivl_reg_report,
    output logic [7:0]                o_change_count,
    output logic                      o_ctl_err,
    input  wire logic                 i_ctl_err_clr,
    output logic                      o_ovl_irq,
    output ubs_pkg::ubs_ivl_t         o_ovl_hold,
    input  wire logic                 i_ovl_ack,
    input  wire logic                 i_spi_sclk,
    input  wire logic                 i_spi_cs_n,
    input  wire logic                 i_spi_mosi,
    output logic                      o_reg_wr,
    output logic                      o_reg_rd,
    output logic [15:0]               o_reg_addr,
    output logic [7:0]                o_reg_wdata
);
    import ubs_pkg::*;

    function automatic logic is_start(input logic [2:0] kind);
        is_start = (kind == KIND_HEAD) || (kind == KIND_MISSED);
    endfunction : is_start

    function automatic logic [7:0] type_of(input logic [2:0] kind);
        case (kind)
            KIND_HEAD:   type_of = TYPE_HEAD;
            KIND_BODY:   type_of = TYPE_BODY;
            KIND_LAST:   type_of = TYPE_LAST;
            KIND_REPORT: type_of = TYPE_REPORT;
            default:     type_of = TYPE_MISSED;
        endcase
    endfunction : type_of

    ////////////////////////////////////////////////////////////////////////
    // block queue and byte sequencer
    ubs_blk_t   q_blk;
    logic       q_valid;
    logic       q_ready;
    ubs_state_t st_reg;
    ubs_state_t st_next;
    ubs_blk_t   cur_reg;
    logic [2:0] chan_reg;
    logic [7:0] byte_reg;
    logic [7:0] byte_next;
    logic       newdesc_reg;

    ubs_fifo #(
        .W     ($bits(ubs_blk_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_valid (i_blk_valid),
        .o_ready (o_blk_ready),
        .i_data  (i_blk),
        .o_valid (q_valid),
        .i_ready (q_ready),
        .o_data  (q_blk)
    );

    wire idle      = st_reg == ST_IDLE;
    wire take      = idle && q_valid;
    wire step      = !idle && i_byte_ready;
    wire cur_start = is_start(cur_reg.kind);
    // start blocks only
    // body, last and report never trigger a channel block mid burst
    wire need_chan = is_start(q_blk.kind) && ((q_blk.chan != chan_reg) ||
                     (i_chan_every_burst && q_blk.kind == KIND_HEAD));
    wire flag_byte_done = (st_reg == ST_BLK_I) && i_byte_ready && cur_start;

    assign q_ready      = idle;
    assign o_byte       = byte_reg;
    assign o_byte_valid = !idle;

    always_comb begin
        st_next   = st_reg;
        byte_next = byte_reg;
        case (st_reg)
            ST_IDLE: begin
                if (q_valid) begin
                    st_next   = need_chan ? ST_CHAN_T : ST_BLK_T;
                    byte_next = need_chan ? TYPE_CHAN : type_of(q_blk.kind);
                end
            end
            ST_CHAN_T: begin
                if (i_byte_ready) begin
                    st_next   = ST_CHAN_P;
                    byte_next = {5'h00, cur_reg.chan};
                end
            end
            ST_CHAN_P: begin
                if (i_byte_ready) begin
                    st_next   = ST_BLK_T;
                    byte_next = type_of(cur_reg.kind);
                end
            end
            ST_BLK_T: begin
                if (i_byte_ready) begin
                    st_next   = ST_BLK_I;
                    byte_next = cur_reg.info;
                    if (cur_start) begin
                        byte_next[NEWDESC_BIT] = newdesc_reg;
                    end
                end
            end
            ST_BLK_I: begin
                if (i_byte_ready) begin
                    st_next = ST_IDLE;
                end
            end
            default: begin
                st_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_reg   <= ST_IDLE;
            byte_reg <= 8'h00;
            cur_reg  <= '0;
        end else begin
            st_reg   <= st_next;
            byte_reg <= byte_next;
            cur_reg  <= take ? q_blk : cur_reg;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            chan_reg <= CHAN_RST;
        end else if (step && st_reg == ST_CHAN_P) begin
            chan_reg <= cur_reg.chan;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control message intake
    wire [2:0] msg_type  = i_ctl_msg[CTL_TYPE_HI -: 3];
    wire       par_ivl   = ^i_ctl_msg;
    wire       par_chg   = ^i_ctl_msg[CTL_TYPE_HI:CHG_PAR_POS];
    wire       is_ivl    = msg_type == MSG_INTERVAL;
    wire       is_chg    = msg_type == MSG_DESC_CHG;
    wire       good_ivl  = i_ctl_valid && is_ivl && !par_ivl;
    wire       good_chg  = i_ctl_valid && is_chg && !par_chg;
    wire       bad_msg   = i_ctl_valid && !good_ivl && !good_chg;
    ubs_ivl_t  ivl_in;
    assign ivl_in = ubs_ivl_t'({i_ctl_msg[CTL_CHAN_HI -: 3],
                                i_ctl_msg[CTL_PAY_HI:1]});

    logic       ivl_valid_reg;
    ubs_ivl_t   ivl_reg;
    logic [7:0] ccc_reg;
    logic       err_reg;

    assign o_ivl_valid      = ivl_valid_reg;
    assign o_ivl            = ivl_reg;
    assign o_ivl_reg_report = ivl_reg.sel == SEL_REG_DEFINED;
    assign o_change_count   = ccc_reg;
    assign o_ctl_err        = err_reg;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ivl_valid_reg <= 1'b0;
            ivl_reg       <= '0;
            ccc_reg       <= 8'h00;
            err_reg       <= 1'b0;
            newdesc_reg   <= 1'b0;
        end else begin
            ivl_valid_reg <= good_ivl;
            ivl_reg       <= good_ivl ? ivl_in : ivl_reg;
            ccc_reg       <= good_chg ? i_ctl_msg[CTL_PAY_HI -: 8] : ccc_reg;
            err_reg       <= bad_msg || (err_reg && !i_ctl_err_clr);
            // a change arriving as the flag is used stays pending
            newdesc_reg   <= good_chg || (newdesc_reg && !flag_byte_done);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // overlap detection against the previous interval
    logic [32:0] prev_end_reg;
    logic        prev_init_reg;
    logic        prev_vld_reg;
    logic        ovl_reg;
    ubs_ivl_t    hold_reg;

    wire new_init = ivl_in.usage == USAGE_INIT_MAINT;
    wire illegal  = good_ivl && prev_vld_reg && !(new_init && prev_init_reg)
                    && ({1'b0, ivl_in.start} < prev_end_reg);

    assign o_ovl_irq  = ovl_reg;
    assign o_ovl_hold = hold_reg;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            prev_end_reg  <= '0;
            prev_init_reg <= 1'b0;
            prev_vld_reg  <= 1'b0;
            ovl_reg       <= 1'b0;
            hold_reg      <= '0;
        end else begin
            if (good_ivl) begin
                prev_end_reg  <= {1'b0, ivl_in.start} + 33'(ivl_in.len);
                prev_init_reg <= new_init;
                prev_vld_reg  <= 1'b1;
            end
            // first offender is kept until software takes it
            ovl_reg  <= illegal || (ovl_reg && !i_ovl_ack);
            hold_reg <= (illegal && (!ovl_reg || i_ovl_ack)) ? ivl_in
                                                              : hold_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // serial register frame, pins synchronised before use
    logic [2:0]  sync1_reg;
    logic [2:0]  sync2_reg;
    logic        sclk_d_reg;
    logic [2:0]  bit_reg;
    logic [1:0]  bidx_reg;
    logic [7:0]  sh_reg;
    logic        wr_dir_reg;
    logic        die_ok_reg;
    logic [15:0] addr_reg;
    logic        wr_reg;
    logic        rd_reg;
    logic [7:0]  wd_reg;
    logic        more_reg;

    wire       cs_act   = !sync2_reg[1];
    wire       rise     = sync2_reg[2] && !sclk_d_reg && cs_act;
    wire [7:0] sh_next  = {sh_reg[6:0], sync2_reg[0]};
    wire       byte_end = rise && (bit_reg == 3'h7);

    assign o_reg_wr    = wr_reg;
    assign o_reg_rd    = rd_reg;
    assign o_reg_addr  = addr_reg;
    assign o_reg_wdata = wd_reg;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sync1_reg  <= 3'h2;
            sync2_reg  <= 3'h2;
            sclk_d_reg <= 1'b0;
        end else begin
            sync1_reg  <= {i_spi_sclk, i_spi_cs_n, i_spi_mosi};
            sync2_reg  <= sync1_reg;
            sclk_d_reg <= sync2_reg[2];
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            bit_reg    <= 3'h0;
            bidx_reg   <= SPI_BYTE_HDR;
            sh_reg     <= 8'h00;
            wr_dir_reg <= 1'b0;
            die_ok_reg <= 1'b0;
            addr_reg   <= 16'h0000;
            wr_reg     <= 1'b0;
            rd_reg     <= 1'b0;
            wd_reg     <= 8'h00;
            more_reg   <= 1'b0;
        end else begin
            wr_reg <= 1'b0;
            rd_reg <= 1'b0;
            if (!cs_act) begin
                bit_reg  <= 3'h0;
                bidx_reg <= SPI_BYTE_HDR;
                more_reg <= 1'b0;
            end else if (rise) begin
                bit_reg <= bit_reg + 3'h1;
                sh_reg  <= sh_next;
            end
            if (byte_end) begin
                bidx_reg <= (bidx_reg == SPI_BYTE_DATA) ? bidx_reg
                                                        : bidx_reg + 2'h1;
                case (bidx_reg)
                    SPI_BYTE_HDR: begin
                        die_ok_reg <= sh_next[7:4] == DIE_SELECT_OWN;
                        wr_dir_reg <= sh_next[0];
                    end
                    SPI_BYTE_AHI: begin
                        addr_reg[15:8] <= sh_next;
                    end
                    SPI_BYTE_ALO: begin
                        addr_reg[7:0] <= sh_next;
                        rd_reg        <= die_ok_reg && !wr_dir_reg;
                    end
                    default: begin
                        // data bytes ignored on reads
                        wd_reg   <= sh_next;
                        wr_reg   <= die_ok_reg && wr_dir_reg;
                        // the write pulse is long gone by the next data
                        // byte, so a frame flag drives the increment
                        addr_reg <= more_reg ? addr_reg + 16'h0001
                                             : addr_reg;
                        more_reg <= 1'b1;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_flag_set;
        @(posedge i_clk) disable iff (i_rst)
        (st_reg == ST_BLK_T && cur_start && newdesc_reg && i_byte_ready)
            |=> o_byte[NEWDESC_BIT];
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("new-descriptor flag missing");

    property p_flag_clr;
        @(posedge i_clk) disable iff (i_rst)
        (st_reg == ST_BLK_T && cur_start && !newdesc_reg && i_byte_ready)
            |=> !o_byte[NEWDESC_BIT];
    endproperty
    a_flag_clr: assert property (p_flag_clr)
        else $error("new-descriptor flag set twice");

    property p_chan_pay;
        @(posedge i_clk) disable iff (i_rst)
        (st_reg == ST_CHAN_P) |-> (o_byte[7:3] == 5'h00 &&
            o_byte[2:0] == cur_reg.chan &&
            ($past(o_byte) == TYPE_CHAN || $past(st_reg) == ST_CHAN_P));
    endproperty
    a_chan_pay: assert property (p_chan_pay)
        else $error("bad channel block");

    property p_chan_before;
        @(posedge i_clk) disable iff (i_rst)
        (take && is_start(q_blk.kind) && q_blk.chan != chan_reg)
            |=> (st_reg == ST_CHAN_T) ##[1:40] (st_reg == ST_BLK_T);
    endproperty
    a_chan_before: assert property (p_chan_before)
        else $error("channel block not sent");

    property p_chan_mid;
        @(posedge i_clk) disable iff (i_rst)
        (st_reg == ST_CHAN_T) |-> cur_start;
    endproperty
    a_chan_mid: assert property (p_chan_mid)
        else $error("channel block inside burst");

    property p_burst_chan;
        @(posedge i_clk) disable iff (i_rst)
        (take && !is_start(q_blk.kind)) |=> (st_reg == ST_BLK_T) &&
            $stable(chan_reg);
    endproperty
    a_burst_chan: assert property (p_burst_chan)
        else $error("burst block changed channel");

    property p_bad_drop;
        @(posedge i_clk) disable iff (i_rst)
        bad_msg |=> (!o_ivl_valid && o_ctl_err);
    endproperty
    a_bad_drop: assert property (p_bad_drop)
        else $error("bad message not discarded");

    property p_ivl_out;
        @(posedge i_clk) disable iff (i_rst)
        good_ivl |=> (o_ivl_valid && o_ivl.start == $past(i_ctl_msg[35:4])
            && o_ivl.flow == $past(i_ctl_msg[67:54]));
    endproperty
    a_ivl_out: assert property (p_ivl_out)
        else $error("interval fields misplaced");

    property p_ovl_hold;
        @(posedge i_clk) disable iff (i_rst)
        (o_ovl_irq && !i_ovl_ack) |=> (o_ovl_irq && $stable(o_ovl_hold));
    endproperty
    a_ovl_hold: assert property (p_ovl_hold)
        else $error("overlap record lost");

    property p_spi_die;
        @(posedge i_clk) disable iff (i_rst)
        o_reg_wr |-> (die_ok_reg && wr_dir_reg);
    endproperty
    a_spi_die: assert property (p_spi_die)
        else $error("write for other die");

    c_chan_switch: cover property (@(posedge i_clk) st_reg == ST_CHAN_P);
    c_overlap: cover property (@(posedge i_clk) illegal);
    c_reg_write: cover property (@(posedge i_clk) o_reg_wr);

endmodule : ubs_sequencer

/* verif/ubs_mac_model.sv */
`timescale 1ns/10ps
module ubs_mac_model (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic [7:0] i_byte,
    input  wire logic       i_byte_valid,
    input  wire logic [1:0] i_mode,
    output logic            o_byte_ready,
    output logic [2:0]      o_cur_chan
);
    import ubs_pkg::*;
    logic [7:0] rx_q [$];
    logic       pay_reg;
    logic       sel_reg;
    logic       tick_reg;
    // mode 0 always ready, 1 every other cycle, 2 stalled
    assign o_byte_ready = (i_mode == 2'h0) || (i_mode == 2'h1 && tick_reg);
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_cur_chan <= CHAN_RST;
            pay_reg <= 1'b0;
            sel_reg <= 1'b0;
            tick_reg <= 1'b0;
            rx_q.delete();
        end else begin
            tick_reg <= ~tick_reg;
            if (i_byte_valid && o_byte_ready) begin
                rx_q.push_back(i_byte);
                pay_reg <= ~pay_reg;
                sel_reg <= !pay_reg && i_byte == TYPE_CHAN;
                if (pay_reg && sel_reg)
                    o_cur_chan <= i_byte[2:0];
            end
        end
    end
endmodule : ubs_mac_model

/* verif/ubs_sequencer_tb.sv */
`timescale 1ns/10ps
module ubs_sequencer_tb;
    import ubs_pkg::*;
    typedef struct packed {
        ubs_blk_t b;
        logic     ch;
        logic     nd;
    } ubs_row_t;
    localparam logic [7:0] TYPES [5] = '{TYPE_HEAD, TYPE_BODY, TYPE_LAST,
        TYPE_REPORT, TYPE_MISSED};
    // kind, channel, info, then channel block and flag expected
    localparam ubs_row_t ROWS [9] = '{
        {KIND_HEAD, 3'h0, 8'h00, 2'h1}, {KIND_BODY, 3'h0, 8'h5a, 2'h0},
        {KIND_LAST, 3'h0, 8'h11, 2'h0}, {KIND_REPORT, 3'h0, 8'h22, 2'h0},
        {KIND_MISSED, 3'h5, 8'h13, 2'h2}, {KIND_MISSED, 3'h5, 8'h07, 2'h0},
        {KIND_HEAD, 3'h7, 8'h10, 2'h2}, {KIND_BODY, 3'h2, 8'h33, 2'h0},
        {KIND_LAST, 3'h2, 8'h44, 2'h0}};
    logic        i_clk, i_rst, i_blk_valid, i_byte_ready, i_chan_every_burst;
    logic        i_ctl_valid, i_ctl_err_clr, i_ovl_ack, i_spi_sclk;
    logic        i_spi_cs_n, i_spi_mosi, o_blk_ready, o_byte_valid;
    logic        o_ivl_valid, o_ivl_reg_report, o_ctl_err, o_ovl_irq;
    logic        o_reg_wr, o_reg_rd;
    logic [7:0]  o_byte, o_change_count, o_reg_wdata, wd;
    logic [15:0] o_reg_addr, wa;
    logic [73:0] i_ctl_msg;
    logic [2:0]  cur_chan;
    logic [1:0]  mode;
    ubs_blk_t    i_blk;
    ubs_ivl_t    o_ivl, o_ovl_hold;
    logic [7:0]  exp_q [$];
    int          n_mismatch, n_compared, wr_n, rd_n, ivl_n, j, t;

    ubs_sequencer uut (.*);
    ubs_mac_model mac (.i_clk(i_clk), .i_rst(i_rst), .i_byte(o_byte),
        .i_byte_valid(o_byte_valid), .i_mode(mode),
        .o_byte_ready(i_byte_ready), .o_cur_chan(cur_chan));

    ////////////////////////////////////////////////////////////////////////
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    // pulses are short, so they are latched here for later checks
    always @(negedge i_clk) begin
        if (o_reg_wr === 1'b1) begin
            wr_n++;
            wa = o_reg_addr;
            wd = o_reg_wdata;
        end
        if (o_reg_rd === 1'b1)
            rd_n++;
        if (o_ivl_valid === 1'b1)
            ivl_n++;
    end

    task conclude;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude
    task chk(string nm, logic [73:0] s, logic [73:0] e);
        n_compared++;
        if (s !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task bound(int k, int lim);
        if (k >= lim) begin
            n_mismatch++;
            conclude();
        end
    endtask : bound
    task push(ubs_row_t r);
        int k;
        i_blk = r.b;
        i_blk_valid = 1'b1;
        for (k = 0; k < 200 && o_blk_ready !== 1'b1; k++)
            @(negedge i_clk);
        bound(k, 200);
        @(negedge i_clk);
        if (r.ch) begin
            exp_q.push_back(TYPE_CHAN);
            exp_q.push_back({5'h0, r.b.chan});
        end
        exp_q.push_back(TYPES[r.b.kind]);
        exp_q.push_back(r.b.kind inside {KIND_HEAD, KIND_MISSED} ?
            {r.b.info[7:5], r.nd, r.b.info[3:0]} : r.b.info);
    endtask : push
    task drain;
        int k;
        i_blk_valid = 1'b0;
        for (k = 0; k < 999 && mac.rx_q.size() < exp_q.size(); k++)
            @(negedge i_clk);
        bound(k, 999);
        while (exp_q.size() > 0)
            chk("byte", mac.rx_q.pop_front(), exp_q.pop_front());
    endtask : drain
    task ctl(logic [73:0] m);
        i_ctl_msg = m;
        i_ctl_valid = 1'b1;
        @(negedge i_clk);
        i_ctl_valid = 1'b0;
        repeat (2) @(negedge i_clk);
    endtask : ctl
    task clr;
        i_ctl_err_clr = 1'b1;
        i_ovl_ack = 1'b1;
        @(negedge i_clk);
        i_ctl_err_clr = 1'b0;
        i_ovl_ack = 1'b0;
        @(negedge i_clk);
    endtask : clr
    task spi(logic [31:0] f);
        int b;
        i_spi_cs_n = 1'b0;
        for (b = 31; b >= 0; b--) begin
            i_spi_mosi = f[b];
            repeat (4) @(negedge i_clk);
            i_spi_sclk = 1'b1;
            repeat (4) @(negedge i_clk);
            i_spi_sclk = 1'b0;
        end
        repeat (4) @(negedge i_clk);
        i_spi_cs_n = 1'b1;
        i_spi_mosi = ~i_spi_mosi;
        repeat (8) @(negedge i_clk);
    endtask : spi
    function ubs_ivl_t ivl(logic [2:0] c, logic [3:0] u, logic [31:0] s);
        return {c, 14'h0155, u, 14'h000a, s, SEL_REG_DEFINED};
    endfunction : ivl
    function logic [73:0] imsg(ubs_ivl_t v);
        return {MSG_INTERVAL, v, ^{MSG_INTERVAL, v}};
    endfunction : imsg
    function logic [73:0] chg(logic [7:0] n);
        return {MSG_DESC_CHG, 3'h0, n, ^{MSG_DESC_CHG, n}, 59'h0};
    endfunction : chg

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {i_blk_valid, i_chan_every_burst, i_ctl_valid, i_spi_sclk} = '0;
        {i_ctl_err_clr, i_ovl_ack, i_spi_mosi, mode, i_blk} = '0;
        {n_mismatch, n_compared, wr_n, rd_n, ivl_n} = '0;
        i_ctl_msg = '0;
        i_spi_cs_n = 1'b1;
        i_rst = 1'b1;
        repeat (6) @(negedge i_clk);
        chk("blk_ready", o_blk_ready, 1);
        chk("byte_valid", o_byte_valid, 0);
        chk("cur_chan", cur_chan, 0);
        i_rst = 1'b0;
        repeat (4) @(negedge i_clk);
        ctl(chg(8'ha5));
        chk("count", o_change_count, 8'ha5);
        mode = 2'h1;
        foreach (ROWS[r])
            push(ROWS[r]);
        drain();
        // a missed block now takes the flag, the head after it does not
        ctl(chg(8'h3c));
        i_chan_every_burst = 1'b1;
        push({KIND_MISSED, 3'h7, 8'h00, 2'h1});
        push({KIND_HEAD, 3'h7, 8'h1f, 2'h2});
        drain();
        i_chan_every_burst = 1'b0;
        mode = 2'h2;
        for (j = 0; j < 24 && o_blk_ready === 1'b1; j++)
            push({KIND_BODY, 3'h0, j[7:0], 2'h0});
        chk("refused", j inside {[16:18]}, 1);
        mode = 2'h1;
        drain();
        ctl(imsg(ivl(3'h1, 4'h5, 32'h64)));
        chk("ivl", o_ivl, ivl(3'h1, 4'h5, 32'h64));
        chk("report", o_ivl_reg_report, 1);
        ctl(imsg(ivl(3'h1, 4'h5, 32'h69)));
        ctl(imsg(ivl(3'h2, 4'h5, 32'h6b)));
        chk("irq", o_ovl_irq, 1);
        chk("hold", o_ovl_hold, ivl(3'h1, 4'h5, 32'h69));
        clr();
        ctl(imsg(ivl(3'h4, USAGE_INIT_MAINT, 32'h12c)));
        ctl(imsg(ivl(3'h6, USAGE_INIT_MAINT, 32'h136)));
        chk("irq", o_ovl_irq, 0);
        chk("ivl", o_ivl, ivl(3'h6, USAGE_INIT_MAINT, 32'h136));
        chk("ivl_cnt", ivl_n, 5);
        t = ivl_n;
        ctl(imsg(ivl(3'h1, 4'h5, 32'h13a)) ^ 74'h1);
        chk("err", o_ctl_err, 1);
        chk("dropped", ivl_n - t, 0);
        chk("irq", o_ovl_irq, 0);
        for (t = 2; t < 8; t++) begin
            clr();
            ctl({t[2:0], 70'h0, ^t[2:0]});
            chk("reserved", o_ctl_err, 1);
        end
        clr();
        chk("err", o_ctl_err, 0);
        spi({DIE_SELECT_OWN, 4'h1, 16'h1234, 8'hab});
        chk("wr", wr_n, 1);
        chk("waddr", wa, 16'h1234);
        chk("wdata", wd, 8'hab);
        spi({DIE_SELECT_OWN, 4'h0, 16'h0042, 8'h00});
        spi({4'h3, 4'h0, 16'h0042, 8'h00});
        chk("rd", rd_n, 1);
        chk("wr", wr_n, 1);
        chk("cur_chan", cur_chan, 7);
        conclude();
    end
endmodule : ubs_sequencer_tb
